// [hdl/usmf_defs.svh]
// Offsets, field positions, reset values of the serial mode/frame unit.
// Assumes 16-bit byte addresses on the plain register port.
`ifndef USMF_DEFS_SVH
`define USMF_DEFS_SVH
`define USMF_MODE_ADDR  16'hff50
`define USMF_RXB_ADDR   16'hff52
`define USMF_TXB_ADDR   16'hff53
`define USMF_ERR_ADDR   16'hff54
`define USMF_TXS_ADDR   16'hff55
`define USMF_CKS_ADDR   16'hff56
`define USMF_BRG_ADDR   16'hff57
`define USMF_CTRL_ADDR  16'hff58
`define USMF_MODE_RST   8'h01
`define USMF_CTRL_RST   6'h16
`define USMF_CKS_RST    4'h0
`define USMF_BRG_RST    8'hff
`define USMF_POWER_BIT  7
`define USMF_TXE_BIT    6
`define USMF_RXE_BIT    5
`define USMF_PSH_BIT    4
`define USMF_PSL_BIT    3
`define USMF_CL_BIT     2
`define USMF_SL_BIT     1
`define USMF_DIR_BIT    1
`define USMF_INV_BIT    0
`define USMF_PE_BIT     2
`define USMF_FE_BIT     1
`define USMF_OVE_BIT    0
`endif

// [hdl/usmf_pkg.sv]
// Types of the serial mode/frame unit.
// Assumes usmf_defs.svh holds all numeric constants.
`default_nettype none
package usmf_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } usmf_req_t;
    typedef struct packed {
        logic serialOutputPin;
        logic outputOwned;
        logic inputOwned;
    } usmf_pins_t;
    typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} usmf_par_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} usmf_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} usmf_rx_t;
endpackage
`default_nettype wire

// [hdl/usmf_top.sv]
// Serial unit: mode register, enable sequencing, frame tx/rx, parity.
// Assumes one 125 MHz clock, sync reset, plain register port.
// Functional notes
// RULE1: all three enables zero means stop mode
// RULE2: mode register at ff50, resets 01
// RULE3: power off stops clock, resets unit
// RULE4: transmit enable off resets transmitter
// RULE5: receive enable off resets receiver
// RULE6: power off: output high, input high
// RULE7: power off clears status and buffers
// RULE8: software disables enables before power off
// RULE9: one byte frames, full duplex
// RULE10: software configures, then power, then enables
// RULE11: buffer write starts frame when enabled
// RULE12: pins owned only when power and enable
// RULE13: start, 7/8 data, parity, 1/2 stops
// RULE14: control bit 1 picks bit order
// RULE15: control bit 0 inverts output
// RULE16: even parity transmit bit
// RULE17: even parity receive check
// RULE18: odd parity transmit bit
// RULE19: odd parity receive check
// RULE20: software keeps parity zero on LIN
// RULE21: zero parity sends 0, never errors
// RULE22: receiver checks one stop bit only
// RULE23: bit timing from baud generator
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "usmf_defs.svh"
`default_nettype none
module usmf_top (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire usmf_pkg::usmf_req_t   busReq,
    output var  logic [7:0]            busRdata,
    input  wire logic                  serialInputPin,
    output var  usmf_pkg::usmf_pins_t  pins
);
    import usmf_pkg::*;

    function automatic logic [2:0] bitIdx(input logic [2:0] n, input logic len8,
                                          input logic lsb);
        bitIdx = lsb ? n : ((len8 ? 3'h7 : 3'h6) - n);
    endfunction
    function automatic logic lastBit(input logic [2:0] n, input logic len8);
        lastBit = (n == (len8 ? 3'h7 : 3'h6));
    endfunction
    function automatic logic parityOf(input logic [7:0] d, input logic len8);
        parityOf = ^{d[7] & len8, d[6:0]};
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] serialModeControl;
    logic [5:0] serialControlRegister;
    logic [3:0] clockSelectRegister;
    logic [7:0] baudDivisorRegister;
    logic [7:0] transmitBuffer;
    logic [7:0] receiveBuffer;
    logic [2:0] receiveErrorStatus;
    logic       txBufFull;
    logic       rxBufFull;
    logic       power;
    logic       txOn;
    logic       rxOn;
    logic       len8;
    logic       lsbFirst;
    logic       twoStop;
    usmf_par_t  parMode;
    logic       wrMode;
    logic       wrCtrl;
    logic       wrTxb;
    logic       rdRxb;
    logic       rdErr;
    logic [7:0] readMux;

    assign power    = serialModeControl[`USMF_POWER_BIT];
    assign txOn     = power & serialModeControl[`USMF_TXE_BIT];
    assign rxOn     = power & serialModeControl[`USMF_RXE_BIT];
    assign len8     = serialModeControl[`USMF_CL_BIT];
    assign twoStop  = serialModeControl[`USMF_SL_BIT];
    assign parMode  = usmf_par_t'(serialModeControl[`USMF_PSH_BIT:`USMF_PSL_BIT]);
    assign lsbFirst = serialControlRegister[`USMF_DIR_BIT];
    assign wrMode   = busReq.wr && busReq.addr == `USMF_MODE_ADDR;
    assign wrCtrl   = busReq.wr && busReq.addr == `USMF_CTRL_ADDR;
    assign wrTxb    = busReq.wr && busReq.addr == `USMF_TXB_ADDR;
    assign rdRxb    = busReq.rd && busReq.addr == `USMF_RXB_ADDR;
    assign rdErr    = busReq.rd && busReq.addr == `USMF_ERR_ADDR;

    // RULE2: mode register reset
    always_ff @(posedge clk) begin
        if (srst) begin
            serialModeControl <= `USMF_MODE_RST;
            serialControlRegister <= `USMF_CTRL_RST;
            clockSelectRegister <= `USMF_CKS_RST;
            baudDivisorRegister <= `USMF_BRG_RST;
        end else begin
            if (wrMode)
                serialModeControl <= busReq.wdata;
            if (wrCtrl)
                serialControlRegister <= busReq.wdata[5:0];
            if (busReq.wr && busReq.addr == `USMF_CKS_ADDR)
                clockSelectRegister <= busReq.wdata[3:0];
            if (busReq.wr && busReq.addr == `USMF_BRG_ADDR)
                baudDivisorRegister <= busReq.wdata;
        end
    end
    AST_MODE_RESET: assert property (disable iff (1'b0) // RULE2
        srst |=> serialModeControl == `USMF_MODE_RST)
        else $error("mode register not 01 after reset");

    ////////////////////////////////////////////////////////////////////////
    // Baud prescaler and divisor
    logic [10:0] preCnt;
    logic        basePulse;
    logic [8:0]  bitLen;
    assign basePulse = power && preCnt == ((11'h1 << clockSelectRegister) - 11'h1);
    assign bitLen    = {baudDivisorRegister, 1'b0};

    // RULE3: clock held while unpowered
    always_ff @(posedge clk) begin
        if (srst || !power || basePulse)
            preCnt <= 11'h0;
        else
            preCnt <= preCnt + 11'h1;
    end
    AST_NO_CLOCK_OFF: assert property (!power |=> preCnt == 11'h0) // RULE3
        else $error("base clock runs while unpowered");

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    usmf_tx_t   txState;
    usmf_tx_t   next_txState;
    logic [8:0] txCnt;
    logic       txTick;
    logic [7:0] txShift;
    logic [2:0] txBitCnt;
    logic       txStopCnt;
    logic       txBit;
    logic       txParBit;

    assign txTick = basePulse && txCnt == bitLen - 9'h1;

    // RULE23: bit timing
    always_ff @(posedge clk) begin
        if (srst || !txOn || txState == TX_IDLE || txTick)
            txCnt <= 9'h0;
        else if (basePulse)
            txCnt <= txCnt + 9'h1;
    end

    // RULE13: frame sequence
    always_comb begin
        next_txState = txState;
        case (txState)
            TX_IDLE:   if (txBufFull) next_txState = TX_START;
            TX_START:  if (txTick) next_txState = TX_DATA;
            TX_DATA:   if (txTick && lastBit(txBitCnt, len8))
                           next_txState = (parMode == PAR_NONE) ? TX_STOP : TX_PARITY;
            TX_PARITY: if (txTick) next_txState = TX_STOP;
            TX_STOP:   if (txTick && (txStopCnt || !twoStop)) next_txState = TX_IDLE;
            default:   next_txState = TX_IDLE;
        endcase
    end

    // RULE4: transmit enable reset
    always_ff @(posedge clk) begin
        if (srst || !txOn)
            txState <= TX_IDLE;
        else
            txState <= next_txState;
    end

    always_ff @(posedge clk) begin
        if (txState == TX_IDLE)
            txShift <= transmitBuffer;
        if (txState != TX_DATA)
            txBitCnt <= 3'h0;
        else if (txTick)
            txBitCnt <= txBitCnt + 3'h1;
        if (txState != TX_STOP)
            txStopCnt <= 1'h0;
        else if (txTick)
            txStopCnt <= 1'h1;
    end

    // RULE11: buffer write starts frame
    always_ff @(posedge clk) begin
        if (srst || !txOn) begin
            txBufFull <= 1'h0;
        end else begin
            if (txState == TX_IDLE)
                txBufFull <= 1'h0;
            if (wrTxb)
                txBufFull <= 1'h1;
        end
        if (wrTxb && txOn)
            transmitBuffer <= busReq.wdata;
    end
    AST_TX_START: assert property (txState == TX_IDLE && txBufFull && txOn // RULE11
        && !$past(srst) |=> txState == TX_START)
        else $error("full buffer did not start a frame");
    AST_TXE_RESET: assert property (!txOn |=> txState == TX_IDLE && !txBufFull) // RULE4
        else $error("transmitter not reset by enable off");

    // RULE16: even parity bit
    // RULE18: odd parity bit
    // RULE21: zero parity bit
    always_comb begin
        case (parMode)
            PAR_EVEN: txParBit = parityOf(txShift, len8);
            PAR_ODD:  txParBit = ~parityOf(txShift, len8);
            default:  txParBit = 1'h0;
        endcase
    end

    // RULE14: bit order
    always_comb begin
        case (txState)
            TX_START:  txBit = 1'h0;
            TX_DATA:   txBit = txShift[bitIdx(txBitCnt, len8, lsbFirst)];
            TX_PARITY: txBit = txParBit;
            default:   txBit = 1'h1;
        endcase
    end
    AST_PAR_EVEN: assert property (txState == TX_PARITY && parMode == PAR_EVEN // RULE16
        |-> txBit == ^{txShift[7] & len8, txShift[6:0]})
        else $error("even parity bit wrong");
    AST_PAR_ODD: assert property (txState == TX_PARITY && parMode == PAR_ODD // RULE18
        |-> txBit != ^{txShift[7] & len8, txShift[6:0]})
        else $error("odd parity bit wrong");
    AST_PAR_ZERO: assert property (txState == TX_PARITY && parMode == PAR_ZERO // RULE21
        |-> !txBit)
        else $error("zero parity bit not 0");

    // RULE1: stop mode pins
    // RULE12: pin ownership
    // RULE15: output inversion
    // RULE6: unpowered high output
    always_ff @(posedge clk) begin
        if (srst) begin
            pins <= '{serialOutputPin: 1'h1, outputOwned: 1'h0, inputOwned: 1'h0};
        end else begin
            pins.serialOutputPin <= txOn ? txBit ^ serialControlRegister[`USMF_INV_BIT]
                                         : 1'h1;
            pins.outputOwned <= txOn;
            pins.inputOwned  <= rxOn;
        end
    end
    AST_INVERT: assert property (txOn |=> pins.serialOutputPin == // RULE15
        ($past(txBit) ^ $past(serialControlRegister[`USMF_INV_BIT])))
        else $error("output polarity wrong");
    AST_OFF_HIGH: assert property (!power |=> pins.serialOutputPin // RULE6
        && !pins.outputOwned && !pins.inputOwned)
        else $error("unpowered pin not high or still owned");

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    usmf_rx_t   rxState;
    usmf_rx_t   next_rxState;
    logic       rxSync1;
    logic       rxSync2;
    logic       rxIn;
    logic       rxPrev;
    logic [8:0] rxCnt;
    logic [8:0] rxLimit;
    logic       rxTick;
    logic [7:0] rxShift;
    logic [2:0] rxBitCnt;
    logic       rxParErr;
    logic       rxDone;

    // RULE6: unpowered input reads high
    assign rxIn    = power ? rxSync2 : 1'h1;
    assign rxLimit = (rxState == RX_START) ? {1'h0, baudDivisorRegister} : bitLen;
    assign rxTick  = basePulse && rxCnt == rxLimit - 9'h1;
    assign rxDone  = rxState == RX_STOP && rxTick;

    always_ff @(posedge clk) begin
        rxSync1 <= serialInputPin;
        rxSync2 <= rxSync1;
        rxPrev  <= srst ? 1'h1 : rxIn;
    end

    // RULE23: bit timing
    always_ff @(posedge clk) begin
        if (srst || !rxOn || rxState == RX_IDLE || rxTick)
            rxCnt <= 9'h0;
        else if (basePulse)
            rxCnt <= rxCnt + 9'h1;
    end

    // RULE22: single stop sampled
    always_comb begin
        next_rxState = rxState;
        case (rxState)
            RX_IDLE:   if (rxPrev && !rxIn) next_rxState = RX_START;
            RX_START:  if (rxTick) next_rxState = rxIn ? RX_IDLE : RX_DATA;
            RX_DATA:   if (rxTick && lastBit(rxBitCnt, len8))
                           next_rxState = (parMode == PAR_NONE) ? RX_STOP : RX_PARITY;
            RX_PARITY: if (rxTick) next_rxState = RX_STOP;
            RX_STOP:   if (rxTick) next_rxState = RX_IDLE;
            default:   next_rxState = RX_IDLE;
        endcase
    end

    // RULE5: receive enable reset
    // RULE9: independent duplex engines
    always_ff @(posedge clk) begin
        if (srst || !rxOn)
            rxState <= RX_IDLE;
        else
            rxState <= next_rxState;
    end
    AST_RXE_RESET: assert property (!rxOn |=> rxState == RX_IDLE) // RULE5
        else $error("receiver not reset by enable off");

    // RULE14: receive bit order
    // RULE17: even parity check
    // RULE19: odd parity check
    always_ff @(posedge clk) begin
        if (rxState == RX_START) begin
            rxShift  <= 8'h00;
            rxBitCnt <= 3'h0;
            rxParErr <= 1'h0;
        end else if (rxTick && rxState == RX_DATA) begin
            rxShift[bitIdx(rxBitCnt, len8, lsbFirst)] <= rxIn;
            rxBitCnt <= rxBitCnt + 3'h1;
        end else if (rxTick && rxState == RX_PARITY) begin
            rxParErr <= (parMode == PAR_EVEN && (parityOf(rxShift, len8) ^ rxIn))
                     || (parMode == PAR_ODD && !(parityOf(rxShift, len8) ^ rxIn));
        end
    end

    // RULE7: power off clears status
    always_ff @(posedge clk) begin
        if (srst || !power) begin
            receiveBuffer <= 8'h00;
            rxBufFull <= 1'h0;
            receiveErrorStatus <= 3'h0;
        end else begin
            if (rdRxb)
                rxBufFull <= 1'h0;
            if (rdErr)
                receiveErrorStatus <= 3'h0;
            if (rxDone) begin
                receiveErrorStatus[`USMF_PE_BIT] <= rxParErr;
                receiveErrorStatus[`USMF_FE_BIT] <= !rxIn;
                receiveErrorStatus[`USMF_OVE_BIT] <= rxBufFull && !rdRxb;
                if (!rxBufFull || rdRxb) begin
                    receiveBuffer <= rxShift;
                    rxBufFull <= 1'h1;
                end
            end
        end
    end
    AST_PWR_CLEAR: assert property (!power |=> receiveErrorStatus == 3'h0 // RULE7
        && !rxBufFull && !txBufFull && receiveBuffer == 8'h00)
        else $error("power off left status set");
    AST_ZERO_NOERR: assert property (rxDone && parMode == PAR_ZERO // RULE21
        |=> !receiveErrorStatus[`USMF_PE_BIT])
        else $error("zero parity flagged an error");

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always_comb begin
        case (busReq.addr)
            `USMF_MODE_ADDR: readMux = serialModeControl;
            `USMF_CTRL_ADDR: readMux = {2'h0, serialControlRegister};
            `USMF_RXB_ADDR:  readMux = receiveBuffer;
            `USMF_ERR_ADDR:  readMux = {5'h00, receiveErrorStatus};
            `USMF_TXS_ADDR:  readMux = {6'h00, txBufFull, txState != TX_IDLE};
            `USMF_CKS_ADDR:  readMux = {4'h0, clockSelectRegister};
            `USMF_BRG_ADDR:  readMux = baudDivisorRegister;
            default:         readMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst || !busReq.rd)
            busRdata <= 8'h00;
        else
            busRdata <= readMux;
    end

    COV_TX_FRAME: cover property (txState == TX_STOP ##1 txState == TX_IDLE);
    COV_RX_FRAME: cover property (rxDone);
    COV_DUPLEX:   cover property (txState == TX_DATA && rxState == RX_DATA);
    COV_PAR_ERR:  cover property (rxDone && rxParErr);
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the serial mode/frame unit.
// Assumes usmf_top, usmf_pkg, usmf_defs.svh and usmf_remote.
`timescale 1ns/10ps
`include "usmf_defs.svh"
`default_nettype none
module tb_top;
    import usmf_pkg::*;
    typedef struct packed {
        logic [4:0] m;
        logic [1:0] c;
        logic [7:0] d;
    } usmf_row_t;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    usmf_req_t   busReq = '0;
    logic [7:0]  busRdata;
    logic        serialIn;
    usmf_pins_t  pinsOut;
    int          error_cnt = 0;
    int          check_count = 0;
    logic [7:0]  v;
    logic [7:0]  mask;
    logic [11:0] rxf;
    logic [11:0] exp;
    logic        lowSeen;
    int          n;
    int          rn;
    logic [3:0]  cksSel = 4'h0;
    usmf_row_t   rows [7] = '{
        '{5'h1c, 2'b10, 8'h55}, '{5'h1c, 2'b00, 8'h55}, '{5'h1c, 2'b01, 8'h55},
        '{5'h12, 2'b10, 8'h36}, '{5'h04, 2'b10, 8'h87}, '{5'h0c, 2'b10, 8'hc1},
        '{5'h16, 2'b00, 8'h07}};
    logic [1:0]  pm [3] = '{2'b11, 2'b10, 2'b01};
    always #4 clk = ~clk;
    usmf_top dut_u (
        .clk            (clk),
        .srst           (srst),
        .busReq         (busReq),
        .busRdata       (busRdata),
        .serialInputPin (serialIn),
        .pins           (pinsOut)
    );
    usmf_remote remote_u (
        .clk    (clk),
        .txLine (pinsOut.serialOutputPin),
        .rxLine (serialIn)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        @(negedge clk);
        d = busRdata;
        @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] want);
        check_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic setup(input logic [4:0] m, input logic [1:0] c, input logic [2:0] en);
        wr(`USMF_MODE_ADDR, 8'h80);
        wr(`USMF_MODE_ADDR, 8'h00);
        wr(`USMF_CKS_ADDR, {4'h0, cksSel});
        wr(`USMF_BRG_ADDR, 8'h08 >> cksSel);
        wr(`USMF_MODE_ADDR, {3'b000, m});
        wr(`USMF_CTRL_ADDR, {6'h00, c});
        wr(`USMF_MODE_ADDR, {3'b100, m});
        wr(`USMF_MODE_ADDR, {en, m});
    endtask
    function automatic logic [11:0] frame(input logic [4:0] m, input logic lsb,
                                          input logic [7:0] d, output int nb);
        logic [11:0] f;
        logic        p;
        int          nd;
        int          i;
        nd = m[2] ? 8 : 7;
        p  = ^(d & (m[2] ? 8'hff : 8'h7f));
        f  = 12'h000;
        nb = 1;
        for (i = 0; i < nd; i++) begin
            f[nb] = lsb ? d[i] : d[nd-1-i];
            nb++;
        end
        if (m[4:3] != 2'b00) begin
            f[nb] = (m[4:3] == 2'b11) ? p : ((m[4:3] == 2'b10) ? ~p : 1'b0);
            nb++;
        end
        f[nb] = 1'b1;
        nb++;
        if (m[1]) begin
            f[nb] = 1'b1;
            nb++;
        end
        return f;
    endfunction
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`USMF_MODE_ADDR, v);
        chk("mode reset", {4'h0, v}, 12'h001);
        chk("stop pins", {9'h000, pinsOut}, 12'h004);
        wr(16'hff51, 8'hff);
        rd(16'hff51, v);
        chk("unmapped", {4'h0, v}, 12'h000);
        wr(`USMF_TXB_ADDR, 8'h00);
        lowSeen = 1'b0;
        repeat (40) @(negedge clk) lowSeen |= ~pinsOut.serialOutputPin;
        chk("no frame off", {11'h000, lowSeen}, 12'h000);
        for (int i = 4; i < 8; i++) begin
            wr(`USMF_MODE_ADDR, {i[2:0], 5'h00});
            repeat (2) @(negedge clk);
            chk("ownership", {10'h000, pinsOut.outputOwned, pinsOut.inputOwned},
                {10'h000, i[1:0]});
        end
        for (int r = 0; r < 7; r++) begin
            setup(rows[r].m, rows[r].c, 3'b111);
            exp  = frame(rows[r].m, rows[r].c[1], rows[r].d, n);
            rxf  = frame(rows[r].m & 5'h1d, rows[r].c[1], rows[r].d, rn);
            mask = rows[r].m[2] ? 8'hff : 8'h7f;
            wr(`USMF_TXB_ADDR, rows[r].d);
            fork
                remote_u.capture(n, rows[r].c[0]);
                begin
                    remote_u.send(rxf, rn);
                    repeat (4) @(posedge clk);
                    rd(`USMF_ERR_ADDR, v);
                    chk("rx status", {4'h0, v}, 12'h000);
                    rd(`USMF_RXB_ADDR, v);
                    chk("rx data", {4'h0, v & mask}, {4'h0, rows[r].d & mask});
                end
            join
            chk("tx frame", remote_u.capBits, exp);
        end
        // prescaled base tick, same bit time
        cksSel = 4'h1;
        for (int i = 0; i < 3; i++) begin
            setup({pm[i], 3'b100}, 2'b10, 3'b101);
            rxf = frame({pm[i], 3'b100}, 1'b1, 8'h55, rn);
            rxf[9] = ~rxf[9];
            remote_u.send(rxf, rn);
            repeat (4) @(posedge clk);
            rd(`USMF_ERR_ADDR, v);
            chk("parity flag", {4'h0, v}, (pm[i] == 2'b01) ? 12'h000 : 12'h004);
            if (i < 2) begin
                rd(`USMF_RXB_ADDR, v);
            end
        end
        wr(`USMF_MODE_ADDR, 8'h80);
        wr(`USMF_MODE_ADDR, 8'h00);
        rd(`USMF_RXB_ADDR, v);
        chk("power off buffer", {4'h0, v}, 12'h000);
        chk("power off pins", {9'h000, pinsOut}, 12'h004);
        setup(5'h04, 2'b10, 3'b111);
        wr(`USMF_TXB_ADDR, 8'ha5);
        rxf = frame(5'h04, 1'b1, 8'h5a, rn);
        fork
            remote_u.send(rxf, rn);
            begin
                repeat (60) @(posedge clk);
                wr(`USMF_MODE_ADDR, 8'h84);
            end
        join
        repeat (20) @(posedge clk);
        rd(`USMF_TXS_ADDR, v);
        chk("tx abort status", {4'h0, v}, 12'h000);
        rd(`USMF_RXB_ADDR, v);
        chk("rx abort buffer", {4'h0, v}, 12'h000);
        chk("tx abort pin", {11'h000, pinsOut.serialOutputPin}, 12'h001);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`USMF_MODE_ADDR, v);
        chk("mode second reset", {4'h0, v}, 12'h001);
        report_and_stop();
    end
endmodule
`default_nettype wire

// [tb/usmf_remote.sv]
// Remote serial transceiver facing the serial mode/frame unit.
// Assumes 16 clocks per bit, whatever prescaler and divisor give it.
`timescale 1ns/10ps
`default_nettype none
module usmf_remote (
    input  wire logic clk,
    input  wire logic txLine,
    output var  logic rxLine
);
    localparam int BIT_CLK = 16;
    logic [11:0] capBits;
    initial rxLine = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // Sample an outgoing frame mid-bit, start bit into bit 0
    task automatic capture(input int nbits, input logic inv);
        int i;
        capBits = 12'h000;
        while ((txLine ^ inv) !== 1'b0) @(negedge clk);
        repeat (BIT_CLK / 2) @(negedge clk);
        for (i = 0; i < nbits; i++) begin
            capBits[i] = txLine ^ inv;
            repeat (BIT_CLK) @(negedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Drive a frame, then back to idle high
    task automatic send(input logic [11:0] bits, input int nbits);
        int i;
        for (i = 0; i < nbits; i++) begin
            rxLine <= bits[i];
            repeat (BIT_CLK) @(posedge clk);
        end
        rxLine <= 1'b1;
    endtask
endmodule
`default_nettype wire
